/* File: src/scan_seq.sv */
// measurement scan sequencer: scan orders, continuous timing and measure commands
`timescale 1ns/1ns
module scan_seq
    import scan_seq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        cmd_valid,
    input  wire logic [5:0]  cmd_addr,
    input  wire logic [5:0]  cmd_suffix,
    output logic             cmd_forward,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             conv_start,
    output logic [4:0]       conv_slot,
    output logic             conv_wire_load,
    input  wire logic        conv_done,
    input  wire logic [13:0] conv_result,
    output logic             result_we,
    output logic [4:0]       result_slot,
    output logic [13:0]      result_data,
    output logic             balance_allow,
    output logic             awake,
    output logic             fault_pin,
    output logic             fault_send,
    output logic             wakeup_send,
    output logic             busy
);
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_PAUSE = 5'b00010,
        ST_ISSUE = 5'b00100,
        ST_WAIT  = 5'b01000,
        ST_END   = 5'b10000
    } state_t;
    typedef enum logic [2:0] {
        PH_VOLT  = 3'd0,
        PH_WIRE  = 3'd1,
        PH_TEMP  = 3'd2,
        PH_MIXED = 3'd3,
        PH_MEAS  = 3'd4
    } phase_t;

    state_t      state;
    phase_t      phase;
    logic [4:0]  step;
    logic        do_wire;
    logic        do_temp;
    logic        cont_run;
    logic        in_cont;
    logic [5:0]  meas_elem;
    logic        fault_seen;
    logic [15:0] ctrl;
    logic [15:0] fault_cfg;
    logic [15:0] limits;
    logic [31:0] tick_cnt;
    logic        ms_tick;
    logic [17:0] ms_cnt;
    logic [17:0] volt_ms;
    logic [19:0] temp_ms;
    logic [19:0] wire_ms;
    logic [19:0] temp_acc;
    logic [19:0] wire_acc;
    logic [5:0]  pause_cnt;
    logic [13:0] aux_one;
    logic [4:0]  slot;
    logic        last_step;

    // slot for a step of a phase
    function automatic logic [4:0] slot_of(input phase_t ph, input logic [4:0] s, input logic [5:0] el);
        logic [4:0] r;
        r = SLOT_SUPPLY;
        unique case (ph)
            PH_VOLT:  r = (s < 5'd12) ? 5'd12 - s : (s == 5'd12 ? SLOT_STACK : SLOT_SUPPLY);
            PH_MIXED: begin
                if (s < 5'd6) r = 5'd12 - s;
                else if (s == 5'd6) r = SLOT_AUX_INPUT_ONE;
                else if (s < 5'd13) r = 5'd13 - s;
                else if (s == 5'd13) r = SLOT_STACK;
                else if (s == 5'd14) r = SLOT_TINT;
                else r = SLOT_SUPPLY;
            end
            PH_WIRE:  r = SLOT_WIRE;
            PH_TEMP:  r = (s < 5'd5) ? SLOT_TINT + s : (s == 5'd5 ? SLOT_LOOP : SLOT_REF);
            PH_MEAS:  r = el[4:0];
            default:  r = SLOT_SUPPLY;
        endcase
        return r;
    endfunction

    function automatic logic [4:0] steps_of(input phase_t ph);
        logic [4:0] n;
        n = 5'd0;
        unique case (ph)
            PH_VOLT:  n = 5'd13;
            PH_MIXED: n = 5'd15;
            PH_WIRE:  n = 5'd12;
            PH_TEMP:  n = 5'd6;
            PH_MEAS:  n = 5'd0;
            default:  n = 5'd0;
        endcase
        return n;
    endfunction

    function automatic logic elem_ok(input logic [5:0] e);
        return (e <= ELEM_CELL_HI) || (e >= ELEM_TINT && e <= ELEM_REF);
    endfunction

    assign slot      = slot_of(phase, step, meas_elem);
    assign last_step = (step == steps_of(phase));
    assign busy      = (state != ST_IDLE);

    // forwarded regardless of whether we take it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) cmd_forward <= 1'b0;
        else cmd_forward <= cmd_valid;
    end

    // register port
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl      <= 16'h0000;
            fault_cfg <= CFG_RESET;
            limits    <= 16'h0000;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL:      ctrl      <= reg_wdata;
                REG_FAULT_CFG: fault_cfg <= reg_wdata;
                REG_LIMITS:    limits    <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) reg_rdata <= 16'h0000;
        else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:      reg_rdata <= ctrl;
                REG_FAULT_CFG: reg_rdata <= fault_cfg;
                REG_LIMITS:    reg_rdata <= limits;
                REG_STATUS:    reg_rdata <= {12'h000, busy, in_cont, cont_run, fault_pin};
                REG_AUX:       reg_rdata <= {2'b00, aux_one};
                default:       reg_rdata <= 16'h0000;
            endcase
        end else reg_rdata <= 16'h0000;
    end

    // millisecond tick from one divider
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tick_cnt <= 32'h00000000;
            ms_tick  <= 1'b0;
        end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h00000000;
            ms_tick  <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
            ms_tick  <= 1'b0;
        end
    end

    // interval figures
    always_comb begin
        logic [3:0] c;
        c = (fault_cfg[3:0] > CODE_MAX) ? CODE_MAX : fault_cfg[3:0];
        volt_ms = 18'(BASE_MS) << c;
        temp_ms = (c <= 4'(TEMP_FIX_CODE)) ? 20'(TEMP_FIX_MS) : {volt_ms, 2'b00};
        if (fault_cfg[CFG_WIRE_BIT]) wire_ms = temp_ms;
        else wire_ms = (c <= 4'(WIRE_FIX_CODE)) ? 20'(TEMP_FIX_MS) : 20'(volt_ms);
    end

    // continuous scan flag and interval scheduling
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cont_run <= 1'b0;
            ms_cnt   <= 18'h00000;
            temp_acc <= 20'h00000;
            wire_acc <= 20'h00000;
        end else begin
            if (cmd_valid && cmd_addr == CMD_SCAN_INHIB) cont_run <= 1'b0;
            else if (cmd_valid && cmd_addr == CMD_SCAN_CONT && state == ST_IDLE) cont_run <= 1'b1;
            if (!cont_run) begin
                ms_cnt   <= 18'h00000;
                temp_acc <= 20'h00000;
                wire_acc <= 20'h00000;
            end else if (ms_tick) begin
                ms_cnt <= (ms_cnt >= volt_ms - 18'h00001) ? 18'h00000 : ms_cnt + 18'h00001;
                if (ms_cnt >= volt_ms - 18'h00001) begin
                    temp_acc <= (temp_acc + 20'(volt_ms) >= temp_ms) ? 20'h00000 : temp_acc + 20'(volt_ms);
                    wire_acc <= (wire_acc + 20'(volt_ms) >= wire_ms) ? 20'h00000 : wire_acc + 20'(volt_ms);
                end
            end
        end
    end

    logic cont_due;
    // an inhibit in the same cycle beats a due scan, so no extra scan slips out after it
    assign cont_due = cont_run && ms_tick && (ms_cnt >= volt_ms - 18'h00001) &&
                      !(cmd_valid && cmd_addr == CMD_SCAN_INHIB);

    // sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            phase      <= PH_VOLT;
            step       <= 5'd0;
            do_wire    <= 1'b0;
            do_temp    <= 1'b0;
            in_cont    <= 1'b0;
            meas_elem  <= 6'h00;
            pause_cnt  <= 6'h00;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    step <= 5'd0;
                    if (cont_due) begin
                        in_cont <= 1'b1;
                        phase   <= PH_VOLT;
                        do_wire <= (wire_acc + 20'(volt_ms) >= wire_ms);
                        do_temp <= (temp_acc + 20'(volt_ms) >= temp_ms);
                        pause_cnt <= 6'(PAUSE_MS);
                        state   <= ctrl[CTRL_PAUSE_BIT] ? ST_PAUSE : ST_ISSUE;
                    end else if (cmd_valid) begin
                        in_cont <= 1'b0;
                        do_wire <= (cmd_addr == CMD_SCAN_ALL);
                        do_temp <= (cmd_addr == CMD_SCAN_ALL);
                        meas_elem <= cmd_suffix;
                        unique case (cmd_addr)
                            CMD_SCAN_VOLT, CMD_SCAN_ALL: begin phase <= PH_VOLT;  state <= ST_ISSUE; end
                            CMD_SCAN_TEMP:  begin phase <= PH_TEMP;  state <= ST_ISSUE; end
                            CMD_SCAN_MIXED: begin phase <= PH_MIXED; state <= ST_ISSUE; end
                            CMD_SCAN_WIRE:  begin phase <= PH_WIRE;  state <= ST_ISSUE; end
                            CMD_MEASURE: if (elem_ok(cmd_suffix)) begin phase <= PH_MEAS; state <= ST_ISSUE; end
                            default: ;
                        endcase
                    end
                end
                ST_PAUSE: begin
                    if (ms_tick) pause_cnt <= pause_cnt - 6'h01;
                    if (ms_tick && pause_cnt == 6'h01) state <= ST_ISSUE;
                end
                ST_ISSUE: state <= ST_WAIT;
                ST_WAIT: if (conv_done) begin
                    if (!last_step) begin
                        step  <= step + 5'd1;
                        state <= ST_ISSUE;
                    end else if (phase == PH_VOLT && do_wire) begin
                        phase <= PH_WIRE; step <= 5'd0; state <= ST_ISSUE;
                    end else if ((phase == PH_VOLT || phase == PH_WIRE) && do_temp) begin
                        phase <= PH_TEMP; step <= 5'd0; state <= ST_ISSUE;
                    end else state <= ST_END;
                end
                ST_END: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign conv_start     = (state == ST_ISSUE);
    assign conv_slot      = slot;
    assign conv_wire_load = (phase == PH_WIRE) && (state == ST_ISSUE || state == ST_WAIT);

    // result storage and compares; wire scan results are not stored
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            result_we   <= 1'b0;
            result_slot <= 5'h00;
            result_data <= 14'h0000;
            aux_one     <= 14'h0000;
            fault_seen  <= 1'b0;
        end else begin
            result_we <= 1'b0;
            if (state == ST_IDLE && (cont_due || cmd_valid)) fault_seen <= 1'b0;
            if (state == ST_WAIT && conv_done) begin
                result_we   <= (phase != PH_WIRE);
                result_slot <= slot;
                result_data <= conv_result;
                if (slot == SLOT_AUX_INPUT_ONE) aux_one <= conv_result;
                if ((phase == PH_VOLT || phase == PH_MIXED) && slot >= 5'd1 && slot <= 5'd12 &&
                    (conv_result > {limits[15:8], 6'h3F} || conv_result < {limits[7:0], 6'h00}))
                    fault_seen <= 1'b1;
                if (phase == PH_TEMP && slot >= SLOT_AUX_INPUT_ONE && slot < SLOT_AUX_INPUT_ONE + 5'd4 &&
                    fault_cfg[CFG_TEN_LSB + 32'(slot - SLOT_AUX_INPUT_ONE)] && conv_result < {limits[7:0], 6'h00})
                    fault_seen <= 1'b1;
                if (phase == PH_WIRE && conv_result < 14'h0010) fault_seen <= 1'b1;
            end
        end
    end

    // fault reporting at scan end; while continuous with stack and sleep set, a wakeup goes out one cycle before the fault
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fault_pin   <= 1'b0;
            fault_send  <= 1'b0;
            wakeup_send <= 1'b0;
        end else begin
            fault_send  <= 1'b0;
            wakeup_send <= 1'b0;
            // clear first so a fault landing with the clearing write is not lost
            if (reg_wr && reg_addr == REG_STATUS) fault_pin <= 1'b0;
            if (state == ST_END && fault_seen) begin
                fault_pin <= 1'b1;
                if (ctrl[CTRL_STACK_BIT] && ctrl[CTRL_SLEEP_BIT] && in_cont) wakeup_send <= 1'b1;
                else fault_send <= 1'b1;
            end
            if (wakeup_send) fault_send <= 1'b1;
        end
    end

    // balancing and power
    always_comb begin
        balance_allow = !(ctrl[CTRL_PAUSE_BIT] && in_cont &&
                          (state == ST_PAUSE || ((state == ST_ISSUE || state == ST_WAIT) && phase == PH_VOLT)));
        awake = !ctrl[CTRL_SLEEP_BIT] || busy || (cont_run && fault_cfg[3:0] <= 4'(AWAKE_MAX_CODE));
    end

    AST_BUSY_IGNORE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_WAIT && cmd_valid && !conv_done) |=> state == ST_WAIT || state == ST_ISSUE)
        else $error("command disturbed a running scan");
    AST_INHIBIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cmd_valid && cmd_addr == CMD_SCAN_INHIB) |=> !cont_run)
        else $error("inhibit did not clear repeat flag");
    AST_CONT_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cmd_valid && cmd_addr == CMD_SCAN_CONT && state == ST_IDLE) |=> cont_run)
        else $error("continuous command did not set flag");
    AST_FAULT_PIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_END && fault_seen) |=> fault_pin)
        else $error("fault pin not raised");
    AST_WAKE_FIRST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wakeup_send |=> fault_send)
        else $error("fault not sent after wakeup");
    AST_END_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state == ST_END |=> state == ST_IDLE)
        else $error("no return to standby");
    AST_VOLT_FIRST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_ISSUE && phase == PH_VOLT && step == 5'd0) |-> conv_slot == 5'd12)
        else $error("voltage scan not starting at cell 12");
    AST_PAUSE_BAL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state == ST_PAUSE |-> !balance_allow)
        else $error("balancing during pause");
    AST_NO_WIRE_DATA: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == ST_WAIT && conv_done && phase == PH_WIRE) |=> !result_we)
        else $error("wire scan stored data");
endmodule // scan_seq

/* File: src/scan_seq_pkg.sv */
// constants for the measurement scan sequencer
package scan_seq_pkg;
    // command addresses
    localparam logic [5:0] CMD_SCAN_VOLT   = 6'h01;
    localparam logic [5:0] CMD_SCAN_TEMP   = 6'h02;
    localparam logic [5:0] CMD_SCAN_MIXED  = 6'h03;
    localparam logic [5:0] CMD_SCAN_WIRE   = 6'h04;
    localparam logic [5:0] CMD_SCAN_ALL    = 6'h05;
    localparam logic [5:0] CMD_SCAN_CONT   = 6'h06;
    localparam logic [5:0] CMD_SCAN_INHIB  = 6'h07;
    localparam logic [5:0] CMD_MEASURE     = 6'h08;
    // measure element suffixes
    localparam logic [5:0] ELEM_STACK      = 6'h00;
    localparam logic [5:0] ELEM_CELL_LO    = 6'h01;
    localparam logic [5:0] ELEM_CELL_HI    = 6'h0C;
    localparam logic [5:0] ELEM_TINT       = 6'h10;
    localparam logic [5:0] ELEM_EXT_LO     = 6'h11;
    localparam logic [5:0] ELEM_EXT_HI     = 6'h14;
    localparam logic [5:0] ELEM_REF        = 6'h15;
    // conversion slot codes shown on conv_slot
    localparam logic [4:0] SLOT_STACK      = 5'h00;
    localparam logic [4:0] SLOT_TINT       = 5'h10;
    localparam logic [4:0] SLOT_AUX_INPUT_ONE       = 5'h11;
    localparam logic [4:0] SLOT_LOOP       = 5'h16;
    localparam logic [4:0] SLOT_REF        = 5'h15;
    localparam logic [4:0] SLOT_WIRE       = 5'h18;
    localparam logic [4:0] SLOT_SUPPLY     = 5'h1E;
    localparam int         NUM_CELLS       = 12;
    localparam int         NUM_EXT         = 4;
    // register offsets of the plain port
    localparam logic [3:0] REG_CTRL        = 4'h0;
    localparam logic [3:0] REG_FAULT_CFG   = 4'h1;
    localparam logic [3:0] REG_LIMITS      = 4'h2;
    localparam logic [3:0] REG_STATUS      = 4'h3;
    localparam logic [3:0] REG_AUX         = 4'h4;
    // field positions
    localparam int         CTRL_PAUSE_BIT  = 0;
    localparam int         CTRL_SLEEP_BIT  = 1;
    localparam int         CTRL_STACK_BIT  = 2;
    localparam int         CFG_WIRE_BIT    = 4;
    localparam int         CFG_TEN_LSB     = 8;
    localparam logic [15:0] CFG_RESET      = 16'h0000;
    // timing
    localparam int         CLK_HZ          = 125000000;
    localparam int         TICK_MS         = 1;
    localparam int         TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
    localparam int         PAUSE_MS        = 10;
    localparam int         BASE_MS         = 16;
    localparam int         TEMP_FIX_MS     = 512;
    localparam int         TEMP_FIX_CODE   = 3;
    localparam int         WIRE_FIX_CODE   = 5;
    localparam int         AWAKE_MAX_CODE  = 2;
    localparam logic [3:0] CODE_MAX        = 4'hC;
endpackage

/* File: test/conv_model.sv */
// converter model answering each conversion request after a short delay
`timescale 1ns/1ns
module conv_model (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        conv_start,
    input  wire logic        low_result,
    output logic             conv_done,
    output logic [13:0]      conv_result
);
    logic [1:0] wait_cnt;
    logic       pending;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pending     <= 1'b0;
            wait_cnt    <= 2'h0;
            conv_done   <= 1'b0;
            conv_result <= 14'h2AAA;
        end else begin
            conv_done   <= 1'b0;
            // result lines flip every cycle outside the done pulse so stale data is never trusted
            conv_result <= ~conv_result;
            if (conv_start) begin
                pending  <= 1'b1;
                wait_cnt <= 2'h2;
            end else if (pending && wait_cnt == 2'h0) begin
                pending     <= 1'b0;
                conv_done   <= 1'b1;
                conv_result <= low_result ? 14'h0005 : 14'h1000;
            end else if (pending) begin
                wait_cnt <= wait_cnt - 2'h1;
            end
        end
    end
endmodule // conv_model

/* File: test/scan_seq_tb.sv */
// self-checking bench for the measurement scan sequencer
`timescale 1ns/1ns
module scan_seq_tb;
    import scan_seq_pkg::*;
    logic ref_clk, sys_rst, cmd_valid, cmd_forward, reg_wr, reg_rd, conv_start, conv_wire_load, conv_done;
    logic result_we, balance_allow, awake, fault_pin, fault_send, wakeup_send, busy, low_result, cont_mode;
    logic [5:0]  cmd_addr, cmd_suffix;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic [4:0]  conv_slot, result_slot;
    logic [13:0] conv_result, result_data;
    logic [4:0]  seen[$], exp_q[$];
    int fails, total_checks, n_we, n_fs, n_wk, n_fwd, n_sent, n_sleep, n_bal, n_v, n_wl;
    scan_seq #(.TICK_CYCLES(10)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_addr(cmd_addr), .cmd_suffix(cmd_suffix), .cmd_forward(cmd_forward), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_start(conv_start), .conv_slot(conv_slot), .conv_wire_load(conv_wire_load),
        .conv_done(conv_done), .conv_result(conv_result), .result_we(result_we), .result_slot(result_slot),
        .result_data(result_data), .balance_allow(balance_allow), .awake(awake), .fault_pin(fault_pin),
        .fault_send(fault_send), .wakeup_send(wakeup_send), .busy(busy));
    conv_model partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .conv_start(conv_start),
        .low_result(low_result), .conv_done(conv_done), .conv_result(conv_result));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (!sys_rst) begin
            if (conv_start) seen.push_back(conv_slot);
            if (result_we) n_we++;
            if (fault_send) n_fs++;
            if (wakeup_send) n_wk++;
            if (cmd_forward) n_fwd++;
            if (conv_start && conv_wire_load !== (conv_slot == SLOT_WIRE)) n_wl++;
            if (cont_mode && awake !== 1'b1) n_sleep++;
            // cells must not see balancing current while they are being converted
            if (cont_mode && conv_start && conv_slot >= 5'h01 && conv_slot <= 5'h0C && balance_allow !== 1'b0) n_bal++;
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        // read data stand only in the cycle after the strobe; take them at its closing edge
        @(posedge ref_clk);
        d = reg_rdata;
    endtask
    task automatic send_cmd(input logic [5:0] a, input logic [5:0] s);
        @(posedge ref_clk);
        cmd_valid <= 1'b1; cmd_addr <= a; cmd_suffix <= s; n_sent++;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk);
        if (i == 2000) begin
            check("idle_timeout", 16'h0001, 16'h0000);
            finish_test();
        end
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic run_scan(input logic [5:0] a, input logic [5:0] s);
        seen.delete();
        send_cmd(a, s);
        @(posedge ref_clk);
        wait_idle();
        check("slot_count", 16'(exp_q.size()), 16'(seen.size()));
        foreach (exp_q[i]) if (i < seen.size()) check("slot", 16'(exp_q[i]), 16'(seen[i]));
    endtask
    initial begin
        sys_rst = 1'b1; cmd_valid = 1'b0; cmd_addr = 6'h00; cmd_suffix = 6'h00; reg_addr = 4'h0;
        reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0; low_result = 1'b0; cont_mode = 1'b0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1 check("reset_out", 16'h000B, {12'h0, awake, fault_pin, balance_allow, busy === 1'b0});
        reg_write(REG_LIMITS, 16'hFF00);
        reg_write(REG_FAULT_CFG, 16'h0F13);
        reg_read(REG_FAULT_CFG, rd);
        check("fault_cfg", 16'h0F13, rd & 16'h0F1F);
        reg_write(REG_FAULT_CFG, 16'h0000);
        exp_q = {5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, SLOT_STACK, SLOT_SUPPLY};
        seen.delete();
        send_cmd(CMD_SCAN_VOLT, 6'h00);
        repeat (4) @(posedge ref_clk);
        send_cmd(CMD_SCAN_TEMP, 6'h00);
        wait_idle();
        check("busy_slots", 16'(exp_q.size()), 16'(seen.size()));
        run_scan(CMD_SCAN_VOLT, 6'h00);
        check("volt_stores", 16'd28, 16'(n_we));
        exp_q = {SLOT_TINT, 5'h11, 5'h12, 5'h13, 5'h14, SLOT_LOOP, SLOT_REF};
        run_scan(CMD_SCAN_TEMP, 6'h00);
        exp_q = {5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07, SLOT_AUX_INPUT_ONE, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01,
                 SLOT_STACK, SLOT_TINT, SLOT_SUPPLY};
        run_scan(CMD_SCAN_MIXED, 6'h00);
        reg_read(REG_AUX, rd);
        check("aux_one", 16'h1000, rd);
        exp_q = {};
        // thirteen tap pins, the bottom one included, so one load step more than cells
        for (int i = 0; i <= NUM_CELLS; i++) exp_q.push_back(SLOT_WIRE);
        n_we = 0;
        low_result <= 1'b1;
        run_scan(CMD_SCAN_WIRE, 6'h00);
        check("wire_stores", 16'h0000, 16'(n_we));
        check("fault_pin", 16'h0001, {15'h0, fault_pin});
        check("fault_send", 16'h0001, 16'(n_fs));
        check("wakeup", 16'h0000, 16'(n_wk));
        reg_read(REG_STATUS, rd);
        check("status_fault", 16'h0001, rd);
        reg_write(REG_STATUS, 16'h0000);
        #1 check("fault_clear", 16'h0000, {15'h0, fault_pin});
        low_result <= 1'b0;
        exp_q = {5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, SLOT_STACK, SLOT_SUPPLY};
        for (int i = 0; i <= NUM_CELLS; i++) exp_q.push_back(SLOT_WIRE);
        exp_q = {exp_q, SLOT_TINT, 5'h11, 5'h12, 5'h13, 5'h14, SLOT_LOOP, SLOT_REF};
        run_scan(CMD_SCAN_ALL, 6'h00);
        for (int i = 0; i <= 6'h15; i++) begin
            if (i > 6'h0C && i < 6'h10) continue;
            exp_q = {5'(i)};
            run_scan(6'(CMD_MEASURE), 6'(i));
            check("meas_slot", 16'(i), 16'(result_slot));
            check("meas_data", 16'h1000, 16'(result_data));
        end
        exp_q = {};
        run_scan(CMD_MEASURE, 6'h0D);
        reg_write(REG_CTRL, 16'h0003);
        seen.delete();
        n_fs = 0;
        send_cmd(CMD_SCAN_CONT, 6'h00);
        // the repeat flag is up one edge after the command; watch sleep and balancing from then on
        @(posedge ref_clk);
        cont_mode = 1'b1;
        // pause plus scan outlast a 16 ms interval here, so only every other interval starts a scan
        repeat (1000) @(posedge ref_clk);
        n_v = 0;
        foreach (seen[i]) if (seen[i] == 5'h0C) n_v++;
        check("cont_scans", 16'h0001, {15'h0, n_v >= 3});
        cont_mode = 1'b0;
        send_cmd(CMD_SCAN_INHIB, 6'h00);
        wait_idle();
        seen.delete();
        repeat (400) @(posedge ref_clk);
        check("inhibit", 16'h0000, 16'(seen.size()));
        check("cont_awake", 16'h0000, 16'(n_sleep));
        check("cont_pause", 16'h0000, 16'(n_bal));
        check("cont_quiet", 16'h0000, 16'(n_fs));
        reg_write(REG_LIMITS, 16'hFF01);
        reg_write(REG_CTRL, 16'h0006);
        low_result <= 1'b1;
        n_fs = 0;
        n_wk = 0;
        send_cmd(CMD_SCAN_CONT, 6'h00);
        repeat (400) @(posedge ref_clk);
        send_cmd(CMD_SCAN_INHIB, 6'h00);
        wait_idle();
        check("cont_wakeup", 16'h0001, {15'h0, n_wk > 0});
        check("cont_fault", 16'(n_wk), 16'(n_fs));
        n_fs = 0;
        exp_q = {SLOT_TINT, 5'h11, 5'h12, 5'h13, 5'h14, SLOT_LOOP, SLOT_REF};
        run_scan(CMD_SCAN_TEMP, 6'h00);
        check("temp_masked", 16'h0000, 16'(n_fs));
        reg_write(REG_FAULT_CFG, 16'h0200);
        run_scan(CMD_SCAN_TEMP, 6'h00);
        check("temp_fault", 16'h0001, 16'(n_fs));
        check("wire_load", 16'h0000, 16'(n_wl));
        check("forwarded", 16'(n_sent), 16'(n_fwd));
        finish_test();
    end
endmodule // scan_seq_tb
